// ==== src/etirq_pkg.sv ====
// Operation
// - five causes: trap, pin, ports, wrap, tick
// - entry waits for instruction completion
// - stack registers then load source vector
// - software trap is never masked
// - mask or disabled enable blocks external
// - take external: latch, enable, mask clear
// - external vector fetch clears the external latch
// - level mode: edge or low latches
// - edge mode: falling edge only latches
// - port option adds four port sources
// - port level needs others low, pin high
// - pin request needs all enabled ports low
// - level mode: request held while active
// - edge mode: port needs fresh rise
// - edge mode: pin needs fresh fall
// - enable bit read/write, resets to one
// - pending flag read-only, set by requests
// - external vector fetch clears flag, writes ignored
// - writing one to clear bit clears flag
// - global mask blocks both timer sources
// - wrap flag with enable requests timer
// - tick flag with enable requests timer
// - entry sets the global mask
// - external vector ahead of timer vector
package etirq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ETIRQ_STATUS_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] ETIRQ_OPTION_OFFSET = 8'h04;
  localparam logic [7:0] ETIRQ_STATE_OFFSET = 8'h08;

  // status/control bit positions
  localparam int ETIRQ_CLEAR_BIT = 0;
  localparam int ETIRQ_ENABLE_BIT = 1;
  localparam int ETIRQ_PENDING_BIT = 3;
  // option bit positions
  localparam int ETIRQ_LEVEL_BIT = 0;
  localparam int ETIRQ_PORT_OPT_BIT = 1;

  localparam logic ETIRQ_ENABLE_RESET = 1'b1;
  localparam logic [1:0] ETIRQ_OPTION_RESET = 2'h0;

  // ----------------------------------------------------------------
  // vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] ETIRQ_VEC_SWI = 16'h03fc;
  localparam logic [15:0] ETIRQ_VEC_EXT = 16'h03fa;
  localparam logic [15:0] ETIRQ_VEC_TIMER = 16'h03f8;

  typedef enum logic [1:0] {
    ETIRQ_IDLE = 2'b00,
    ETIRQ_STACK = 2'b01,
    ETIRQ_VECTOR = 2'b11
  } etirq_state_type;

  typedef enum logic [1:0] {
    ETIRQ_SRC_NONE = 2'h0,
    ETIRQ_SRC_SWI = 2'h1,
    ETIRQ_SRC_EXT = 2'h2,
    ETIRQ_SRC_TIMER = 2'h3
  } etirq_src_type;

  typedef struct packed {
    logic instr_done;
    logic software_trap_instruction;
    logic global_mask;
    logic stack_done;
  } etirq_core_in_type;

  typedef struct packed {
    logic irq_start;
    logic stack_push;
    logic set_mask;
    logic vector_load;
    logic [15:0] vector_addr;
  } etirq_core_out_type;

  typedef struct packed {
    logic counter_wrap_flag;
    logic counter_wrap_int_enable;
    logic periodic_tick_flag;
    logic periodic_tick_int_enable;
  } etirq_timer_type;

endpackage

// ==== src/etirq_ctrl.sv ====
module etirq_ctrl #(
  parameter int ADDR_WIDTH = 8,
  parameter int PORT_PINS = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // request pins
  input wire logic ext_request_n,
  input wire logic [PORT_PINS-1:0] port_request_pins,
  // timer and core
  input wire etirq_pkg::etirq_timer_type timer_in,
  input wire etirq_pkg::etirq_core_in_type core_in,
  output etirq_pkg::etirq_core_out_type core_out
);
  import etirq_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge history
  // ----------------------------------------------------------------
  logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
  logic [PORT_PINS-1:0] port_meta_reg, port_sync_reg, port_prev_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ext_meta_reg <= 1'b1;
      ext_sync_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
      port_meta_reg <= '0;
      port_sync_reg <= '0;
      port_prev_reg <= '0;
    end else begin
      ext_meta_reg <= ext_request_n;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      port_meta_reg <= port_request_pins;
      port_sync_reg <= port_meta_reg;
      port_prev_reg <= port_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic enable_reg;
  logic level_reg, port_opt_reg;
  logic latch_reg;
  etirq_state_type state_reg;
  etirq_src_type src_reg;

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  wire ports_used = port_opt_reg;
  wire [PORT_PINS-1:0] port_live = port_sync_reg & {PORT_PINS{ports_used}};
  wire ext_low = ~ext_sync_reg;
  wire ext_fall = ext_prev_reg & ~ext_sync_reg;
  wire ports_all_low = ~|port_live;

  // external pin counts only while every enabled port is low
  wire ext_active = level_reg ? ext_low : ext_fall;
  wire ext_set = ext_active & ports_all_low;

  // one port counts only when it is the sole high one and pin is high
  logic [PORT_PINS-1:0] port_set;
  genvar g;
  generate
    for (g = 0; g < PORT_PINS; g++) begin : g_port
      wire others_low = ~|(port_live & ~(PORT_PINS'(1) << g));
      wire rise = port_live[g] & ~port_prev_reg[g];
      wire act = level_reg ? port_live[g] : rise;
      assign port_set[g] = act & others_low & ext_sync_reg;
    end
  endgenerate

  wire latch_set = ext_set | (|port_set);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire commit = access & pready;
  wire [7:0] word_addr = 8'(paddr);
  wire hit_sc = word_addr == ETIRQ_STATUS_CONTROL_OFFSET;
  wire hit_opt = word_addr == ETIRQ_OPTION_OFFSET;
  wire hit_state = word_addr == ETIRQ_STATE_OFFSET;
  wire mapped = hit_sc | hit_opt | hit_state;
  wire wr_lane0 = commit & pwrite & pstrb[0];
  wire wr_sc = wr_lane0 & hit_sc;
  wire wr_opt = wr_lane0 & hit_opt;
  wire sw_clear = wr_sc & pwdata[ETIRQ_CLEAR_BIT];

  // ----------------------------------------------------------------
  // interrupt decision at instruction boundary
  // ----------------------------------------------------------------
  wire timer_req = (timer_in.counter_wrap_flag & timer_in.counter_wrap_int_enable)
                 | (timer_in.periodic_tick_flag & timer_in.periodic_tick_int_enable);
  wire ext_take = latch_reg & enable_reg & ~core_in.global_mask;
  wire timer_take = timer_req & ~core_in.global_mask;
  wire boundary = (state_reg == ETIRQ_IDLE) & core_in.instr_done;

  // trap belongs to its own instruction, so it wins at its boundary
  // explicit cast: a conditional between enum items is plain integral to strict tools
  wire etirq_src_type pick = etirq_src_type'(
    core_in.software_trap_instruction ? ETIRQ_SRC_SWI
    : ext_take ? ETIRQ_SRC_EXT
    : timer_take ? ETIRQ_SRC_TIMER
    : ETIRQ_SRC_NONE);
  wire start = boundary & (pick != ETIRQ_SRC_NONE);
  wire vec_fetch = state_reg == ETIRQ_VECTOR;
  wire ext_fetch = vec_fetch & (src_reg == ETIRQ_SRC_EXT);

  function automatic logic [15:0] vec_of(input etirq_src_type s);
    case (s)
      ETIRQ_SRC_SWI: vec_of = ETIRQ_VEC_SWI;
      ETIRQ_SRC_EXT: vec_of = ETIRQ_VEC_EXT;
      default: vec_of = ETIRQ_VEC_TIMER;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  etirq_state_type state_next;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ETIRQ_IDLE: begin
        if (start) begin
          state_next = ETIRQ_STACK;
        end
      end
      ETIRQ_STACK: begin
        if (core_in.stack_done) begin
          state_next = ETIRQ_VECTOR;
        end
      end
      ETIRQ_VECTOR: begin
        state_next = ETIRQ_IDLE;
      end
      default: begin
        state_next = ETIRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= ETIRQ_IDLE;
      src_reg <= ETIRQ_SRC_NONE;
    end else begin
      state_reg <= state_next;
      if (start) begin
        src_reg <= pick;
      end
    end
  end

  // core handshake outputs, all registered
  etirq_core_out_type core_out_reg;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      core_out_reg <= '0;
      core_out_reg.vector_addr <= ETIRQ_VEC_TIMER;
    end else begin
      core_out_reg.irq_start <= start;
      core_out_reg.stack_push <= state_next == ETIRQ_STACK;
      core_out_reg.set_mask <= start;
      core_out_reg.vector_load <= state_next == ETIRQ_VECTOR;
      if (start) begin
        core_out_reg.vector_addr <= vec_of(pick);
      end
    end
  end
  assign core_out = core_out_reg;

  // ----------------------------------------------------------------
  // request latch and software bits
  // ----------------------------------------------------------------
  // a new request in the clearing cycle survives the clear
  wire latch_next = latch_set | (latch_reg & ~(ext_fetch | sw_clear));

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      latch_reg <= 1'b0;
      enable_reg <= ETIRQ_ENABLE_RESET;
      level_reg <= ETIRQ_OPTION_RESET[ETIRQ_LEVEL_BIT];
      port_opt_reg <= ETIRQ_OPTION_RESET[ETIRQ_PORT_OPT_BIT];
    end else begin
      latch_reg <= latch_next;
      if (wr_sc) begin
        enable_reg <= pwdata[ETIRQ_ENABLE_BIT];
      end
      if (wr_opt) begin
        level_reg <= pwdata[ETIRQ_LEVEL_BIT];
        port_opt_reg <= pwdata[ETIRQ_PORT_OPT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read and response
  // ----------------------------------------------------------------
  logic [31:0] rd_sc, rd_opt, rd_state;
  always_comb begin
    rd_sc = '0;
    rd_sc[ETIRQ_ENABLE_BIT] = enable_reg;
    rd_sc[ETIRQ_PENDING_BIT] = latch_reg;
    rd_opt = '0;
    rd_opt[ETIRQ_LEVEL_BIT] = level_reg;
    rd_opt[ETIRQ_PORT_OPT_BIT] = port_opt_reg;
    // state word: pin image, timer request, sequencer state and source
    rd_state = {16'h0000, 4'(port_sync_reg), 3'h0, ext_sync_reg,
                2'h0, timer_req, 1'b0, state_reg, src_reg};
  end
  wire [31:0] rd_mux = hit_sc ? rd_sc : hit_opt ? rd_opt : hit_state ? rd_state : 32'h0;

  // one wait state keeps every bus output straight from a flop
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~mapped;
      prdata_reg <= (access & ~pready_reg & ~pwrite) ? rd_mux : 32'h0;
    end
  end
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

endmodule

// ==== verification/etirq_src.sv ====
module etirq_src (
  // clock and commanded levels {pin_low, ports}
  input wire logic ref_clk,
  input wire logic [4:0] want,
  // request pins
  output logic ext_request_n,
  output logic [3:0] port_request_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins move just after an edge, so no edge ever samples a changing pin
  initial {ext_request_n, port_request_pins} = 5'h10;
  always @(posedge ref_clk) {ext_request_n, port_request_pins} <= {!want[4], want[3:0]};
endmodule

// ==== verification/etirq_chk.sv ====
module etirq_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb answer
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // core handshake
  input wire etirq_pkg::etirq_core_in_type core_in,
  input wire etirq_pkg::etirq_core_out_type core_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import etirq_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // idle seen from outside: neither stacking nor in the vector cycle
  wire logic idle = !core_out.stack_push && !core_out.vector_load;
  wire logic start = core_out.irq_start;
  wire logic push = core_out.stack_push;
  wire logic vload = core_out.vector_load;
  wire logic done = core_in.instr_done;
  wire logic trap = core_in.software_trap_instruction;
  wire logic swi_vec = core_out.vector_addr == ETIRQ_VEC_SWI;
  AST_ENTRY: assert property (start |-> $past(done)) else $error("early entry");
  AST_MASK_SET: assert property (start |-> core_out.set_mask && push) else $error("no mask");
  AST_TRAP: assert property (done && trap && idle |=> start && swi_vec)
    else $error("trap not taken");
  AST_MASKED: assert property (done && core_in.global_mask && !trap |=> !start)
    else $error("masked entry");
  AST_VECTOR: assert property (push && core_in.stack_done |=> vload && !push)
    else $error("no vector");
  AST_ONE_VECTOR: assert property (vload |=> !vload && !push) else $error("long vector");
  AST_APB_SLOT: assert property (psel && !penable |-> !pready ##2 pready ##1 !pready)
    else $error("bad answer slot");
  AST_IDLE_BUS: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus not idle");
  cover property (vload && core_out.vector_addr == ETIRQ_VEC_EXT);
  cover property (vload && core_out.vector_addr == ETIRQ_VEC_TIMER);
  cover property (pready && pslverr);
endmodule
bind etirq_ctrl etirq_chk i_etirq_chk (.ref_clk, .resetn, .psel, .penable, .pready, .pslverr,
  .prdata, .core_in, .core_out);

// ==== verification/test_ext_and_timer_irq_logic.sv ====
module test_ext_and_timer_irq_logic;
  timeunit 1ns;
  timeprecision 100ps;
  import etirq_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, ext_request_n, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] port_request_pins;
  logic [4:0] want = 5'h00;
  etirq_timer_type timer_in = '0;
  etirq_core_in_type core_in = '0;
  etirq_core_out_type core_out;
  int fails = 0, comparisons = 0;
  initial forever #12.5 ref_clk = !ref_clk;
  etirq_ctrl i_etirq_ctrl (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .pready, .prdata, .pslverr, .ext_request_n, .port_request_pins, .timer_in,
    .core_in, .core_out);
  etirq_src i_etirq_src (.ref_clk, .want, .ext_request_n, .port_request_pins);
  task automatic stop_test(input int hung);
    fails += hung;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    fails += int'(seen !== exp);
    if (seen !== exp) $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask
  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge ref_clk);
    if (n == 20) stop_test(1);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // enough edges for pin, two sync stages and the latch
  task automatic pins(input logic [4:0] w);
    want <= w;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic enter(input logic trap, input logic [15:0] vec, input logic go);
    @(posedge ref_clk);
    {core_in.instr_done, core_in.software_trap_instruction} <= {1'b1, trap};
    @(posedge ref_clk);
    {core_in.instr_done, core_in.software_trap_instruction} <= 2'b00;
    @(negedge ref_clk);
    chk(core_out.irq_start, go);
    @(posedge ref_clk);
    core_in.stack_done <= go;
    @(posedge ref_clk);
    core_in.stack_done <= 1'b0;
    @(negedge ref_clk);
    chk(core_out.vector_load, go);
    if (go) chk(core_out.vector_addr, vec);
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h00, 32'h2);
    rd(8'h08, 32'h100);
    apb(1'b0, 8'h0c, 32'h0);
    chk({r[30:0], e}, 32'h1);
    pins(5'h10);
    rd(8'h00, 32'ha);
    apb(1'b1, 8'h00, 32'hb);
    rd(8'h00, 32'h2);
    pins(5'h00);
    pins(5'h10);
    apb(1'b1, 8'h00, 32'h2);
    rd(8'h00, 32'ha);
    core_in.global_mask <= 1'b1;
    enter(1'b0, 16'h0, 1'b0);
    core_in.global_mask <= 1'b0;
    timer_in <= '1;
    enter(1'b0, ETIRQ_VEC_EXT, 1'b1);
    rd(8'h00, 32'h2);
    for (int i = 0; i < 3; i++) begin
      timer_in <= etirq_timer_type'(i == 2 ? 4'ha : 4'h3 << 2 * i);
      enter(1'b0, ETIRQ_VEC_TIMER, i < 2);
    end
    timer_in <= '1;
    core_in.global_mask <= 1'b1;
    enter(1'b0, 16'h0, 1'b0);
    enter(1'b1, ETIRQ_VEC_SWI, 1'b1);
    timer_in <= '0;
    core_in.global_mask <= 1'b0;
    apb(1'b1, 8'h04, 32'h1);
    rd(8'h00, 32'ha);
    pins(5'h00);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h00, 32'h3);
    pins(5'h04);
    rd(8'h00, 32'ha);
    rd(8'h08, 32'h4101);
    apb(1'b1, 8'h04, 32'h2);
    pins(5'h00);
    apb(1'b1, 8'h00, 32'h3);
    pins(5'h01);
    rd(8'h00, 32'ha);
    apb(1'b1, 8'h00, 32'h3);
    pins(5'h11);
    rd(8'h00, 32'h2);
    stop_test(0);
  end
endmodule
